/* File: hw/cief_pkg.sv */
/*
  Constants for the core interrupt enable and flag block: register map,
  field positions, reset values.
  Assumes a classic Wishbone slave with 32-bit data, byte addressed.
*/
package cief_pkg;
  localparam logic [3:0] CIEF_ADDR_CTRL = 4'h0;
  localparam logic [3:0] CIEF_ADDR_STATUS = 4'h4;
  localparam logic [3:0] CIEF_ADDR_CLEAR = 4'h8;
  localparam logic [3:0] CIEF_ADDR_ENABLE = 4'hC;
  localparam int CIEF_ADDR_W = 4;
  localparam int CIEF_BIT_PORT_FLAG = 0;
  localparam int CIEF_BIT_EXT_FLAG = 1;
  localparam int CIEF_BIT_TMR_FLAG = 2;
  localparam int CIEF_BIT_PORT_EN = 3;
  localparam int CIEF_BIT_EXT_EN = 4;
  localparam int CIEF_BIT_TMR_EN = 5;
  localparam logic [7:0] CIEF_CTRL_RESET = 8'h00;
  localparam logic [2:0] CIEF_EVT_RESET = 3'h0;
  localparam int CIEF_PORT_W = 4;
endpackage : cief_pkg

/* File: hw/cief_sync.sv */
/*
  Two-flop synchroniser for a bus of pin inputs.
  Assumes inputs asynchronous to sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module cief_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } cief_sync_t;
  cief_sync_t r;
  cief_sync_t next_r;

  always_comb begin
    next_r.meta = async_in;
    next_r.sync = r.meta;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sync_out = r.sync;
endmodule : cief_sync
`default_nettype wire

/* File: hw/cief_top.sv */
/*
  Interrupt enable and flag register of the core: enables for timer
  overflow, external pin and port change; sticky flags set by hardware.
  Also an event status / clear / enable trio driving one irq line.
  Assumes classic Wishbone master, pins asynchronous, timer wrap is a
  one-cycle pulse from logic on sys_clk.
*/
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module cief_top
  import cief_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [cief_pkg::CIEF_ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Interrupt sources
  input wire logic timer_zero_wrap,
  input wire logic ext_irq_pin,
  input wire logic [cief_pkg::CIEF_PORT_W-1:0] upper_port_pins,
  // Interrupt outputs
  output logic core_irq_req,
  output logic event_irq
);
  import cief_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [2:0] evt_status;
    logic [2:0] evt_enable;
    logic ext_prev;
    logic [CIEF_PORT_W-1:0] port_prev;
    logic [2:0] warm;
    logic [31:0] dat;
    logic ack;
    logic irq;
    logic evt_irq;
  } cief_state_t;

  cief_state_t r;
  cief_state_t next_r;
  logic ext_sync;
  logic [CIEF_PORT_W-1:0] port_sync;

  // Full four-bit compare, so aliases of a register never answer
  function automatic logic cief_hit(input logic [CIEF_ADDR_W-1:0] adr, input logic [CIEF_ADDR_W-1:0] reg_adr);
    return adr == reg_adr;
  endfunction : cief_hit

  // Event vector shares the flag layout of the control byte
  function automatic logic [7:0] cief_set_flags(input logic [7:0] ctrl, input logic [2:0] evt);
    logic [7:0] flags;
    flags = ctrl;
    if (evt[CIEF_BIT_TMR_FLAG]) begin
      flags[CIEF_BIT_TMR_FLAG] = 1'b1;
    end
    if (evt[CIEF_BIT_EXT_FLAG]) begin
      flags[CIEF_BIT_EXT_FLAG] = 1'b1;
    end
    if (evt[CIEF_BIT_PORT_FLAG]) begin
      flags[CIEF_BIT_PORT_FLAG] = 1'b1;
    end
    return flags;
  endfunction : cief_set_flags

  // Global enable gating belongs to the core; this is the masked request
  function automatic logic cief_masked_req(input logic [7:0] ctrl);
    logic tmr_req;
    logic ext_req;
    logic port_req;
    tmr_req = ctrl[CIEF_BIT_TMR_EN] && ctrl[CIEF_BIT_TMR_FLAG];
    ext_req = ctrl[CIEF_BIT_EXT_EN] && ctrl[CIEF_BIT_EXT_FLAG];
    port_req = ctrl[CIEF_BIT_PORT_EN] && ctrl[CIEF_BIT_PORT_FLAG];
    return tmr_req || ext_req || port_req;
  endfunction : cief_masked_req

  // Clear register is write-only and reads zero, as do unmapped addresses
  function automatic logic [31:0] cief_read_word(input logic [CIEF_ADDR_W-1:0] adr, input logic [7:0] ctrl,
    input logic [2:0] status, input logic [2:0] enable);
    logic [31:0] word;
    word = 32'h0000_0000;
    if (cief_hit(adr, CIEF_ADDR_CTRL)) begin
      word = {24'h00_0000, ctrl};
    end
    if (cief_hit(adr, CIEF_ADDR_STATUS)) begin
      word = {29'h0000_0000, status};
    end
    if (cief_hit(adr, CIEF_ADDR_ENABLE)) begin
      word = {29'h0000_0000, enable};
    end
    return word;
  endfunction : cief_read_word

  cief_sync #(.WIDTH(1)) u_ext_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(ext_irq_pin),
    .sync_out(ext_sync)
  );

  cief_sync #(.WIDTH(CIEF_PORT_W)) u_port_sync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .async_in(upper_port_pins),
    .sync_out(port_sync)
  );

  logic wr_stb;
  logic rd_stb;
  logic ext_evt;
  logic port_evt;
  logic [2:0] evt;
  logic [7:0] wr_byte;

  always_comb begin
    wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !r.ack && wb_sel_i[0];
    rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !r.ack;
    wr_byte = wb_dat_i[7:0];
    // External event on a rising edge; edge polarity select is outside this block
    ext_evt = r.warm[2] && ext_sync && !r.ext_prev;
    // Any of the upper pins differs from the last sampled value
    port_evt = r.warm[2] && (port_sync != r.port_prev);
    evt = {timer_zero_wrap, ext_evt, port_evt};

    next_r = r;
    next_r.ext_prev = ext_sync;
    next_r.port_prev = port_sync;
    // History counts only once both sync stages hold post-reset samples;
    // a pin held high through reset would otherwise look like an edge
    next_r.warm = {r.warm[1:0], 1'b1};
    next_r.ack = wb_cyc_i && wb_stb_i && !r.ack;
    next_r.dat = 32'h0000_0000;

    if (wr_stb && cief_hit(wb_adr_i, CIEF_ADDR_CTRL)) begin
      next_r.ctrl = wr_byte;
    end
    if (wr_stb && cief_hit(wb_adr_i, CIEF_ADDR_CLEAR)) begin
      next_r.evt_status = r.evt_status & ~wr_byte[2:0];
    end
    if (wr_stb && cief_hit(wb_adr_i, CIEF_ADDR_ENABLE)) begin
      next_r.evt_enable = wr_byte[2:0];
    end

    // Sets come after the write so an event in the clearing cycle wins
    next_r.ctrl = cief_set_flags(next_r.ctrl, evt);
    next_r.evt_status = next_r.evt_status | evt;

    next_r.irq = cief_masked_req(next_r.ctrl);
    next_r.evt_irq = |(next_r.evt_status & next_r.evt_enable);

    if (rd_stb) begin
      next_r.dat = cief_read_word(wb_adr_i, r.ctrl, r.evt_status, r.evt_enable);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      r.ctrl <= CIEF_CTRL_RESET;
      r.evt_status <= CIEF_EVT_RESET;
      r.evt_enable <= CIEF_EVT_RESET;
      r.ext_prev <= 1'b0;
      r.port_prev <= '0;
      r.warm <= 3'h0;
      r.dat <= 32'h0000_0000;
      r.ack <= 1'b0;
      r.irq <= 1'b0;
      r.evt_irq <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  assign wb_dat_o = r.dat;
  assign wb_ack_o = r.ack;
  assign core_irq_req = r.irq;
  assign event_irq = r.evt_irq;
endmodule : cief_top
`default_nettype wire

/* File: verif/cief_chk.sv */
/* Checker on the cief_top ports.
   Assumes the bind after the module. */
`timescale 1ns/1ps
`default_nettype none
module cief_chk (
  // Clock and bus
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  // Events and irqs
  input wire logic timer_zero_wrap,
  input wire logic core_irq_req,
  input wire logic event_irq
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic wr = wb_cyc_i & wb_stb_i & wb_we_i;
  wire logic ctrl_wr = wr & ~wb_ack_o & (wb_adr_i == 4'h0) & wb_sel_i[0];
  sequence s_tmr_armed;
    ctrl_wr && wb_dat_i[5] ##1 wb_ack_o ##1 timer_zero_wrap && !wb_cyc_i;
  endsequence
  chk_tmr_gate: assert property (s_tmr_armed |=> core_irq_req) else $error("irq late");
  chk_all_mask: assert property (ctrl_wr && wb_dat_i[5:3] == 3'h0 |=> !core_irq_req) else $error("unmasked");
  chk_irq_held: assert property (core_irq_req && !wr |=> core_irq_req) else $error("irq lost");
  chk_irq_fall: assert property ($fell(core_irq_req) |-> $past(wr)) else $error("irq fell");
  chk_evt_held: assert property (event_irq && !wr |=> event_irq) else $error("evt lost");
  chk_ack_due: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  chk_ack_once: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
endmodule : cief_chk
bind cief_top cief_chk chk_u (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
  .wb_ack_o, .timer_zero_wrap, .core_irq_req, .event_irq);
`default_nettype wire

/* File: verif/cief_top_tb.sv */
/* Bench for cief_top.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
`default_nettype none
module cief_top_tb;
  logic sys_clk = 1'h0, rst_b = 1'h0, wb_cyc_i = 1'h0, wb_stb_i = 1'h0, wb_we_i = 1'h0;
  logic timer_zero_wrap = 1'h0, ext_irq_pin = 1'h0, wb_ack_o, core_irq_req, event_irq;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h1, upper_port_pins = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, exp_q[$];
  int mismatches = 0, samples_checked = 0, cycles = 0;
  always #12.5 sys_clk = ~sys_clk;
  cief_top dut_u (.sys_clk, .rst_b, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .timer_zero_wrap, .ext_irq_pin, .upper_port_pins, .core_irq_req, .event_irq);
  task chk(input logic [31:0] seen, input logic [31:0] want);
    samples_checked++;
    if (seen !== want) begin
      mismatches++;
      $display("[ERR] %0t got %h want %h", $time, seen, want);
    end
  endtask : chk
  // Reads note their expected word; the monitor below pops it at ack
  task bus(input logic we, input logic [3:0] adr, input logic [7:0] d);
    @(posedge sys_clk);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_dat_i <= {24'h0, d};
    if (!we) exp_q.push_back({24'h0, d});
    do @(posedge sys_clk); while (wb_ack_o !== 1'h1);
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
  endtask : bus
  // Pins held five cycles so sync and flag stage settle; the wrap is a one-cycle pulse
  task ev(input int i);
    if (i == 0) upper_port_pins <= upper_port_pins ^ 4'(1 + $urandom % 15);
    if (i == 1) ext_irq_pin <= 1'h1;
    if (i == 2) timer_zero_wrap <= 1'h1;
    @(posedge sys_clk);
    timer_zero_wrap <= 1'h0;
    repeat (4) @(posedge sys_clk);
    ext_irq_pin <= 1'h0;
    @(negedge sys_clk);
  endtask : ev
  task tally_and_finish;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  always @(posedge sys_clk) if (wb_ack_o === 1'h1 && wb_we_i === 1'h0) chk(wb_dat_o, exp_q.pop_front());
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      tally_and_finish;
    end
  end
  initial begin
    void'($urandom(32'h1f47));
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'h1;
    bus(1'h0, 4'h0, 8'h00);
    bus(1'h0, 4'h2, 8'h00);
    for (int i = 0; i < 3; i++) begin
      bus(1'h1, 4'h0, 8'h38 & ~(8'h08 << i));
      ev(i);
      chk(32'(core_irq_req), 32'h0);
      bus(1'h0, 4'h0, (8'h38 & ~(8'h08 << i)) | (8'h01 << i));
      bus(1'h1, 4'h0, 8'h08 << i);
      ev(i);
      chk(32'(core_irq_req), 32'h1);
      bus(1'h0, 4'h0, (8'h08 << i) | (8'h01 << i));
    end
    bus(1'h1, 4'hC, 8'h07);
    bus(1'h0, 4'h4, 8'h07);
    @(negedge sys_clk);
    chk(32'(event_irq), 32'h1);
    bus(1'h1, 4'h8, 8'h07);
    bus(1'h0, 4'h4, 8'h00);
    @(negedge sys_clk);
    chk(32'(event_irq), 32'h0);
    bus(1'h1, 4'h0, 8'h00);
    bus(1'h0, 4'h0, 8'h00);
    @(negedge sys_clk);
    chk(32'(core_irq_req), 32'h0);
    // A write without byte lane 0 must leave the control byte alone
    @(posedge sys_clk);
    wb_sel_i <= 4'h0;
    bus(1'h1, 4'h0, 8'hFF);
    wb_sel_i <= 4'h1;
    bus(1'h0, 4'h0, 8'h00);
    // Reset in mid-run with pins held away from zero must not fake an edge
    bus(1'h1, 4'h0, 8'h3F);
    upper_port_pins <= 4'hA;
    ext_irq_pin <= 1'h1;
    rst_b <= 1'h0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'h1;
    repeat (5) @(posedge sys_clk);
    bus(1'h0, 4'h0, cief_pkg::CIEF_CTRL_RESET);
    bus(1'h0, 4'h4, {5'h00, cief_pkg::CIEF_EVT_RESET});
    @(negedge sys_clk);
    chk(32'(core_irq_req), 32'h0);
    @(negedge sys_clk);
    tally_and_finish;
  end
endmodule : cief_top_tb
`default_nettype wire
